/* File: wdt_defines.svh */
// Watchdog timer constants: divider ratios, reset values and timing counts
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH

// ============================================================
// Prescaler ratios
`define WDT_DIV_SLOW 14'h3fff
`define WDT_DIV_FAST 14'h00ff
`define WDT_PRE_W 14

// ============================================================
// Counter
`define WDT_CNT_W 16
`define WDT_CNT_MAX 16'hFFFF
// First pass after reset runs from the default reload, not from zero
`define WDT_CNT_RST 16'hff00
// Value the counter wraps to on overflow
`define WDT_CNT_WRAP 16'h0000

// ============================================================
// Reset defaults: 256 ticks at divide-by-256 make 65,536 clocks, about 6.5 ms at 10 MHz
`define WDT_RELOAD_RST 16'hff00
`define WDT_FAST_RST 1'b1
`define WDT_DEF_INTERVAL_US 6500
`define WDT_REF_CLK_MHZ 10
`define WDT_DEF_INTERVAL_CYC (`WDT_DEF_INTERVAL_US * `WDT_REF_CLK_MHZ)

// ============================================================
// Last prewarn count; the reset request follows prewarning by 16 system clocks
`define WDT_PREWARN_CYCLES 4'hf
`define WDT_PW_W 4

`endif

/* File: wdt_pkg.sv */
// Watchdog timer types and shared helper functions
package wdt_pkg;
  `include "wdt_defines.svh"

  // ============================================================
  // Main state machine, Gray coded along run -> prewarn -> reset request
  typedef enum logic [1:0] {
    WDT_RUN = 2'b00,
    WDT_PREWARN = 2'b01,
    WDT_RESREQ = 2'b11
  } wdt_state_e;

  // ============================================================
  // Register images
  typedef struct packed {
    logic enabled;
    logic fast_sel;
    logic [15:0] reload;
    logic [15:0] count;
    wdt_state_e fsm;
    logic [3:0] pw_cnt;
    logic prewarn;
    logic resreq;
    logic started;
  } wdt_s;

  typedef struct packed {
    logic [13:0] cnt;
  } wdt_pre_s;

  // ============================================================
  // Terminal prescaler count for the selected ratio
  function automatic logic [13:0] wdt_div_limit(input logic fast_sel);
    wdt_div_limit = fast_sel ? `WDT_DIV_FAST : `WDT_DIV_SLOW;
  endfunction

endpackage

/* File: wdt_prescaler.sv */
// Watchdog prescaler: divides the system clock by 16,384 or 256
`timescale 1ns/1ns
module wdt_prescaler
  import wdt_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Control
  input wire logic run,
  input wire logic clear,
  input wire logic fast_sel,
  // Tick out
  output logic tick
);

  wdt_pre_s s_ff;
  wdt_pre_s nxt_s;
  logic at_end;

  // Greater-or-equal: a switch to the short ratio late in a long pass wraps at once
  assign at_end = (s_ff.cnt >= wdt_div_limit(fast_sel));
  // Tick is combinational so the counter steps in the same edge the divider wraps
  assign tick = run && !clear && at_end;

  // ============================================================
  // Divider
  always_comb begin
    nxt_s = s_ff;
    if (clear) begin
      nxt_s.cnt = 14'h0000;
    end else if (run) begin
      if (at_end) begin
        nxt_s.cnt = 14'h0000;
      end else begin
        nxt_s.cnt = s_ff.cnt + 14'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // A selector change mid-pass beyond the new limit must still wrap
  a_pre_bound: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (run && !clear && s_ff.cnt > wdt_div_limit(fast_sel)) |=> (s_ff.cnt == 14'h0000))
    else $error("prescaler did not wrap at its limit");

endmodule // wdt_prescaler

/* File: wdt_top.sv */
// Watchdog timer: 16-bit up counter, prescaler, prewarning and reset request
//
// Functional notes
// - Watchdog is enabled right after every reset, without any software action.
// - Disable instruction stops the watchdog, enable instruction resumes it, until overflow; after overflow the reset request still follows.
// - On overflow, prewarning interrupt first, then reset request.
// - 16-bit counter ticks at system clock divided by 16,384 or 256.
// - Counter loads from a software-programmable reload value.
// - Each service before overflow loads reload value into counter and clears the prescaler.
// - Reset defaults give 6.5 ms interval at a 10 MHz clock.
`timescale 1ns/1ns
`include "wdt_defines.svh"
module wdt_top
  import wdt_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Instruction strobes from the core
  input wire logic wd_disable_instr,
  input wire logic wd_enable_instr,
  input wire logic wd_service,
  // Configuration
  input wire logic cfg_write,
  input wire logic [15:0] wd_reload_value,
  input wire logic cfg_fast_prescale,
  // Events
  output logic prewarn_irq,
  output logic reset_req,
  // Status
  output logic wd_active,
  output logic [15:0] wd_count
);

  wdt_s s_ff;
  wdt_s nxt_s;
  logic tick;
  logic pre_run;
  logic pre_clear;
  logic in_run;

  assign in_run = (s_ff.fsm == WDT_RUN);
  // ============================================================
  // Prescaler control
  // Prescaler halts once the overflow has been taken, so no stray ticks
  assign pre_run = s_ff.enabled && in_run;
  assign pre_clear = wd_service && in_run;

  wdt_prescaler u_pre (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .run(pre_run),
    .clear(pre_clear),
    .fast_sel(s_ff.fast_sel),
    .tick(tick)
  );

  // ============================================================
  // Next state
  always_comb begin
    nxt_s = s_ff;
    nxt_s.prewarn = 1'b0;
    nxt_s.started = 1'b1;
    if (cfg_write) begin
      nxt_s.reload = wd_reload_value;
      nxt_s.fast_sel = cfg_fast_prescale;
    end
    // disable and enable strobes
    // Enable wins a tie: the fail-safe side
    if (wd_disable_instr) begin
      nxt_s.enabled = 1'b0;
    end
    if (wd_enable_instr) begin
      nxt_s.enabled = 1'b1;
    end
    unique case (s_ff.fsm)
      WDT_RUN: begin
        if (wd_service) begin
          nxt_s.count = s_ff.reload;
        end else if (tick) begin
          if (s_ff.count == `WDT_CNT_MAX) begin
            nxt_s.count = `WDT_CNT_WRAP;
            nxt_s.fsm = WDT_PREWARN;
            nxt_s.prewarn = 1'b1;
            nxt_s.pw_cnt = 4'h0;
          end else begin
            nxt_s.count = s_ff.count + 16'h0001;
          end
        end
      end
      WDT_PREWARN: begin
        // Neither service nor disable can hold back the reset once overflowed
        nxt_s.pw_cnt = s_ff.pw_cnt + 4'h1;
        if (s_ff.pw_cnt == `WDT_PREWARN_CYCLES) begin
          nxt_s.fsm = WDT_RESREQ;
          nxt_s.resreq = 1'b1;
        end
      end
      WDT_RESREQ: begin
        nxt_s.resreq = 1'b1;
      end
      default: begin
        nxt_s.fsm = WDT_RESREQ;
        nxt_s.resreq = 1'b1;
      end
    endcase
  end

  // ============================================================
  // State register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff.enabled <= 1'b1;
      // defaults give 256 ticks at divide by 256
      s_ff.fast_sel <= `WDT_FAST_RST;
      s_ff.reload <= `WDT_RELOAD_RST;
      s_ff.count <= `WDT_CNT_RST;
      s_ff.fsm <= WDT_RUN;
      s_ff.pw_cnt <= 4'h0;
      s_ff.prewarn <= 1'b0;
      s_ff.resreq <= 1'b0;
      s_ff.started <= 1'b0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ============================================================
  // Outputs
  assign prewarn_irq = s_ff.prewarn;
  assign reset_req = s_ff.resreq;
  assign wd_active = s_ff.enabled;
  assign wd_count = s_ff.count;

  // ============================================================
  // Assertions
  // active at first cycle
  a_enabled_at_reset: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !s_ff.started |-> (wd_active && wd_count == 16'hff00 && !reset_req))
    else $error("watchdog not armed after reset");

  a_disable_stops: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wd_disable_instr && !wd_enable_instr) |=> !wd_active)
    else $error("disable instruction ignored");

  a_enable_resumes: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wd_enable_instr |=> wd_active)
    else $error("enable instruction ignored");

  a_frozen_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!wd_active && !wd_service && in_run) |=> ($stable(wd_count) && !prewarn_irq))
    else $error("counter moved while disabled");

  a_prewarn_gap: assert property (@(posedge sys_clk) disable iff (!rst_n)
    prewarn_irq |-> (!reset_req ##1 (!reset_req && !prewarn_irq) [*8] ##8 reset_req))
    else $error("reset request not 16 cycles after prewarning");

  a_resreq_cause: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(reset_req) |-> ($past(s_ff.fsm) == WDT_PREWARN && $past(s_ff.pw_cnt) == 4'hF))
    else $error("reset request without prewarning");

  a_resreq_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reset_req |=> (reset_req && !prewarn_irq))
    else $error("reset request dropped");

  a_service_reload: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wd_service && in_run) |=> (wd_count == $past(s_ff.reload) && !prewarn_irq))
    else $error("service did not reload counter");

  a_tick_spacing: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (tick && s_ff.fast_sel && !cfg_write) |=> !tick [*8])
    else $error("ticks too close together");

  a_count_step: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (tick && !wd_service && wd_count != 16'hFFFF) |=> (wd_count == $past(wd_count) + 16'h0001))
    else $error("counter did not step by one");

  a_overflow_warn: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (tick && !wd_service && wd_count == 16'hFFFF) |=> (prewarn_irq && wd_count == 16'h0000))
    else $error("overflow without prewarning");

  a_warn_cause: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(prewarn_irq) |-> ($past(tick) && $past(wd_count) == 16'hFFFF))
    else $error("prewarning without overflow");

  a_default_ratio: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !s_ff.started |-> (s_ff.fast_sel && s_ff.reload == 16'hff00))
    else $error("reset defaults wrong");

  a_warn_count_held: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !in_run |=> $stable(wd_count))
    else $error("counter moved after overflow");

  a_warn_no_cancel: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !in_run |=> !in_run)
    else $error("overflow sequence was cancelled");

endmodule // wdt_top

/* File: tb_top.sv */
// Self-checking testbench for the watchdog timer top level
`timescale 1ns/1ns
module tb_top;
  import wdt_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wd_disable_instr = 1'b0;
  logic wd_enable_instr = 1'b0;
  logic wd_service = 1'b0;
  logic cfg_write = 1'b0;
  logic [15:0] wd_reload_value = 16'h0000;
  logic cfg_fast_prescale = 1'b1;
  logic prewarn_irq;
  logic reset_req;
  logic wd_active;
  logic [15:0] wd_count;
  int n_errors = 0;
  int checks = 0;
  logic [15:0] held;

  always #5 sys_clk = ~sys_clk;

  wdt_top i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n),
    .wd_disable_instr(wd_disable_instr), .wd_enable_instr(wd_enable_instr), .wd_service(wd_service),
    .cfg_write(cfg_write), .wd_reload_value(wd_reload_value), .cfg_fast_prescale(cfg_fast_prescale),
    .prewarn_irq(prewarn_irq), .reset_req(reset_req), .wd_active(wd_active), .wd_count(wd_count)
  );

  // ============================================================
  // Helpers
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  // Waits n edges, then steps past the edge so registered outputs have settled
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // One-cycle strobe pulse; mask is {cfg_write, enable, disable, service}
  task automatic op(input logic [3:0] m, input logic [15:0] v, input logic f);
    @(posedge sys_clk);
    {cfg_write, wd_enable_instr, wd_disable_instr, wd_service} <= m;
    wd_reload_value <= v;
    cfg_fast_prescale <= f;
    @(posedge sys_clk);
    {cfg_write, wd_enable_instr, wd_disable_instr, wd_service} <= 4'h0;
    #1;
  endtask

  task automatic end_sim();
    $display("errors %0d, checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ============================================================
  // Scenarios
  task automatic t_reset_state();
    chk("wd_active", 16'h0001, wd_active);
    chk("wd_count", 16'hff00, wd_count);
    chk("reset_req", 16'h0000, reset_req);
    chk("prewarn_irq", 16'h0000, prewarn_irq);
  endtask

  // Defaults: reload 16'hff00 at divide by 256, so 256 ticks of 256 clocks reach overflow
  task automatic t_defaults();
    op(4'b0001, 16'h0000, 1'b1);
    chk("default reload", 16'hff00, wd_count);
    wt(255);
    chk("count before tick", 16'hff00, wd_count);
    wt(1);
    chk("count after tick", 16'hff01, wd_count);
  endtask

  task automatic t_reload();
    op(4'b1000, 16'h1234, 1'b1);
    wt(2);
    chk("count after cfg only", 16'hff01, wd_count);
    op(4'b0001, 16'h0000, 1'b1);
    chk("count after service", 16'h1234, wd_count);
    wt(200);
    op(4'b0001, 16'h0000, 1'b1);
    chk("count after reservice", 16'h1234, wd_count);
    wt(200);
    chk("prescaler cleared", 16'h1234, wd_count);
  endtask

  task automatic t_disable();
    wt(100);
    op(4'b0010, 16'h0000, 1'b1);
    chk("active after disable", 16'h0000, wd_active);
    held = wd_count;
    wt(600);
    chk("frozen count", held, wd_count);
    op(4'b0001, 16'h0000, 1'b1);
    chk("service while disabled", 16'h1234, wd_count);
    op(4'b0110, 16'h0000, 1'b1);
    chk("enable wins tie", 16'h0001, wd_active);
    wt(256);
    chk("count resumes", 16'h1235, wd_count);
  endtask

  // A switch to the short ratio late in a long pass must tick at once
  task automatic t_slow();
    op(4'b1000, 16'hfffe, 1'b0);
    op(4'b0001, 16'h0000, 1'b0);
    wt(16383);
    chk("slow before tick", 16'hfffe, wd_count);
    wt(1);
    chk("slow after tick", 16'hffff, wd_count);
    op(4'b0001, 16'h0000, 1'b0);
    chk("slow reservice", 16'hfffe, wd_count);
    wt(300);
    op(4'b1000, 16'hfffe, 1'b1);
    chk("no tick at switch", 16'hfffe, wd_count);
    wt(1);
    chk("short ratio at once", 16'hffff, wd_count);
  endtask

  task automatic t_overflow();
    op(4'b1000, 16'hffff, 1'b1);
    op(4'b0001, 16'h0000, 1'b1);
    wt(255);
    chk("no early prewarn", 16'h0000, prewarn_irq);
    wt(1);
    chk("wrapped count", 16'h0000, wd_count);
    chk("prewarn pulse", 16'h0001, prewarn_irq);
    chk("no early reset", 16'h0000, reset_req);
    wt(1);
    chk("prewarn one cycle", 16'h0000, prewarn_irq);
    op(4'b0011, 16'h0000, 1'b1);
    chk("service ignored", 16'h0000, wd_count);
    chk("disable after overflow", 16'h0000, wd_active);
    op(4'b0100, 16'h0000, 1'b1);
    chk("enable after overflow", 16'h0001, wd_active);
    wt(10);
    chk("reset gap", 16'h0000, reset_req);
    wt(1);
    chk("reset request", 16'h0001, reset_req);
    chk("count held", 16'h0000, wd_count);
    wt(20);
    chk("reset held", 16'h0001, reset_req);
    // Second reset in mid-run must bring back the armed state and the default count
    @(posedge sys_clk);
    rst_n <= 1'b0;
    wt(3);
    t_reset_state();
    @(posedge sys_clk);
    rst_n <= 1'b1;
    wt(1);
    chk("armed after reset", 16'h0001, wd_active);
    chk("count after reset", 16'hff00, wd_count);
    chk("no request after reset", 16'h0000, reset_req);
  endtask

  // ============================================================
  // Main sequence and watchdog
  initial begin
    wt(15);
    t_reset_state();
    @(posedge sys_clk);
    rst_n <= 1'b1;
    wt(1);
    t_reset_state();
    t_defaults();
    t_reload();
    t_disable();
    t_slow();
    t_overflow();
    end_sim();
  end

  // Whole run is about 20,000 clocks; twice that means a hang
  initial begin
    repeat (40000) @(posedge sys_clk);
    n_errors++;
    end_sim();
  end
endmodule // tb_top
